// File: rtl/mcrd_ctrl.v
// Code-read DMA control: registers, ring fetch, FIFO and target write path
`timescale 1ns/100ps
`default_nettype none
`include "mcrd_map.vh"
// Function
// - Flag a timeout when a target write cycle lasts over 64 clocks
// - Timeout flag clears by writing one; a set beats a clear
// - FIFO-empty bit reads one when the code buffer is empty
// - Purge bit holds buffer empty; resets to one
// - Three-bit target select for code writes, reset zero
// - Three-bit register select inside target, reset zero
// - Buffer size codes 0-5 give 8..256 kbyte; 6,7 act as 64
// - Report step codes give 8..256 kbyte interrupts; 6,7 act as 16
// - Clearing fetch enable halts fetches, pointer kept; setting resumes
// - Fetch while enabled and FIFO level below threshold, reset 6
// - Without wrap, fetching stops at buffer end
// - With wrap, pointer returns to start and fetching continues
// - Reserved control bits read zero and ignore writes
// - Sixteen-bit doubleword pointer, writable only while fetch disabled
// - Report status bit set on each step, write one clears, set wins
// - Base address low two bits are fixed zero
module mcrd_ctrl #(
   parameter FIFO_LOG2 = 3
) (
   input  wire        mclk_i,
   input  wire        resetn_i,
   // AHB-Lite slave
   input  wire        hsel_i,
   input  wire [11:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg  [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // Host memory read request
   output reg         mem_req_o,
   output reg  [31:0] mem_addr_o,
   input  wire        mem_ack_i,
   input  wire [31:0] mem_data_i,
   // Local peripheral bus code write
   output reg         tgt_wr_o,
   output reg  [2:0]  tgt_select_o,
   output reg  [2:0]  tgt_register_o,
   output reg  [31:0] tgt_data_o,
   input  wire        target_wait_strobe_n_i,
   output wire        irq_o
);
   // Fetch state machine, one-hot
   localparam ST_IDLE = 2'b01;
   localparam ST_REQ  = 2'b10;
   // Full-width copy of the base reset value, so its low bits can be cut on purpose
   localparam [31:0] BASE_RST = `MCRD_BASE_RST;

   reg         timeout_flag_r;
   reg         purge_r;
   reg  [2:0]  tgt_sel_r;
   reg  [2:0]  tgt_reg_r;
   reg  [2:0]  size_code_r;
   reg  [2:0]  step_code_r;
   reg         fetch_en_r;
   reg  [2:0]  thr_r;
   reg         wrap_r;
   reg  [29:0] base_r;
   reg  [15:0] ptr_r;
   reg  [1:0]  irq_stat_r;
   reg  [1:0]  irq_mask_r;
   reg  [1:0]  state_r;
   reg         at_end_r;
   reg         wait_s1_r;
   reg         wait_s2_r;
   // AHB address phase capture
   reg         wr_pend_r;
   reg  [11:0] wr_addr_r;

   wire        fifo_empty;
   wire        fifo_full;
   wire [FIFO_LOG2:0] fifo_level;
   wire [31:0] fifo_rd_data;
   wire        fifo_pop;
   wire        fifo_push;
   wire        tmo_pulse;
   wire        report_pulse;
   wire        addr_ok;
   wire        ptr_last;
   wire [15:0] ptr_inc;
   wire        ctrl_wr;
   wire [31:0] ctrl_rd;
   wire [1:0]  stat_clr;
   wire [1:0]  stat_set;

   // Buffer size in doublewords minus one; codes 6 and 7 fall back to 64 kbyte
   function [15:0] size_mask;
      input [2:0] code;
      begin
         case (code)
            3'h0:    size_mask = 16'h07ff;
            3'h1:    size_mask = 16'h0fff;
            3'h2:    size_mask = 16'h1fff;
            3'h3:    size_mask = 16'h3fff;
            3'h4:    size_mask = 16'h7fff;
            3'h5:    size_mask = 16'hffff;
            default: size_mask = 16'h3fff;
         endcase
      end
   endfunction

   // Report step in doublewords minus one; codes 6 and 7 fall back to 16 kbyte
   function [15:0] step_mask;
      input [2:0] code;
      begin
         case (code)
            3'h0:    step_mask = 16'h07ff;
            3'h1:    step_mask = 16'h0fff;
            3'h2:    step_mask = 16'h1fff;
            3'h3:    step_mask = 16'h3fff;
            3'h4:    step_mask = 16'h7fff;
            3'h5:    step_mask = 16'hffff;
            default: step_mask = 16'h0fff;
         endcase
      end
   endfunction

   // Zero-wait slave, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // Write data phase follows the captured address phase
   always @(posedge mclk_i) begin
      if (!resetn_i) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end else if (hready_i) begin
         wr_pend_r <= hsel_i && htrans_i[1] && hwrite_i;
         wr_addr_r <= haddr_i;
      end
   end

   // Read data is registered at the address phase so it stands in the data phase
   always @(posedge mclk_i) begin
      if (!resetn_i)
         hrdata_o <= 32'h00000000;
      else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
         case (haddr_i)
            `MCRD_BASE_OFS: hrdata_o <= {base_r, 2'b00};
            `MCRD_CTRL_OFS: hrdata_o <= ctrl_rd;
            `MCRD_PTR_OFS:  hrdata_o <= {16'h0000, ptr_r};
            `MCRD_STAT_OFS: hrdata_o <= {30'h00000000, irq_stat_r};
            `MCRD_MASK_OFS: hrdata_o <= {30'h00000000, irq_mask_r};
            default:        hrdata_o <= 32'h00000000;               // Unmapped reads zero
         endcase
      end
   end

   // Reserved positions are tied low in the read image
   assign ctrl_rd = {1'b0, timeout_flag_r, fifo_empty, purge_r,
                     5'h00, tgt_sel_r, 1'b0, tgt_reg_r, 1'b0, size_code_r,
                     1'b0, step_code_r, fetch_en_r, 3'h0, thr_r, wrap_r};

   assign ctrl_wr  = wr_pend_r && (wr_addr_r == `MCRD_CTRL_OFS);

   // Control fields; reserved bits of hwdata are simply not stored
   always @(posedge mclk_i) begin
      if (!resetn_i) begin
         purge_r     <= 1'b1;
         tgt_sel_r   <= 3'h0;
         tgt_reg_r   <= 3'h0;
         size_code_r <= `MCRD_SIZE_RST;
         step_code_r <= `MCRD_STEP_RST;
         fetch_en_r  <= 1'b0;
         thr_r       <= `MCRD_THR_RST;
         wrap_r      <= 1'b0;
         base_r      <= BASE_RST[31:2];
         irq_mask_r  <= 2'b00;
      end else begin
         if (ctrl_wr) begin
            purge_r     <= hwdata_i[`MCRD_PURGE_BIT];
            tgt_sel_r   <= hwdata_i[`MCRD_TGT_HI:`MCRD_TGT_LO];
            tgt_reg_r   <= hwdata_i[`MCRD_REG_HI:`MCRD_REG_LO];
            size_code_r <= hwdata_i[`MCRD_SIZE_HI:`MCRD_SIZE_LO];
            step_code_r <= hwdata_i[`MCRD_STEP_HI:`MCRD_STEP_LO];
            fetch_en_r  <= hwdata_i[`MCRD_FETCH_BIT];
            thr_r       <= hwdata_i[`MCRD_THR_HI:`MCRD_THR_LO];
            wrap_r      <= hwdata_i[`MCRD_WRAP_BIT];
         end
         if (wr_pend_r && wr_addr_r == `MCRD_BASE_OFS)
            base_r <= hwdata_i[31:2];
         if (wr_pend_r && wr_addr_r == `MCRD_MASK_OFS)
            irq_mask_r <= hwdata_i[1:0];
      end
   end

   // Timeout flag: write one clears, a hardware set in the same cycle wins
   always @(posedge mclk_i) begin
      if (!resetn_i)
         timeout_flag_r <= 1'b0;
      else if (tmo_pulse)
         timeout_flag_r <= 1'b1;
      else if (ctrl_wr && hwdata_i[`MCRD_TIMEOUT_BIT])
         timeout_flag_r <= 1'b0;
   end

   // Interrupt status: sticky, write-one-to-clear, set beats clear
   assign stat_set = {tmo_pulse, report_pulse};
   assign stat_clr = (wr_pend_r && wr_addr_r == `MCRD_STAT_OFS) ? hwdata_i[1:0] : 2'b00;
   always @(posedge mclk_i) begin
      if (!resetn_i)
         irq_stat_r <= 2'b00;
      else
         irq_stat_r <= (irq_stat_r & ~stat_clr) | stat_set;
   end
   assign irq_o = |(irq_stat_r & irq_mask_r);

   // Pointer arithmetic within the selected ring size
   assign ptr_inc  = ptr_r + 16'h0001;
   assign ptr_last = ((ptr_r & size_mask(size_code_r)) == size_mask(size_code_r));
   assign fifo_push = (state_r == ST_REQ) && mem_ack_i;
   // A step boundary is crossed when the low bits of the new pointer are all zero
   assign report_pulse = fifo_push &&
                         ((ptr_inc & step_mask(step_code_r)) == 16'h0000);

   // Request a doubleword only while the level is below threshold
   assign addr_ok = fetch_en_r && !purge_r && !at_end_r &&
                    (fifo_level < {{(FIFO_LOG2-2){1'b0}}, thr_r}) && !fifo_full;

   // Fetch engine; a cleared enable lets the pending read finish then idles
   always @(posedge mclk_i) begin
      if (!resetn_i) begin
         state_r    <= ST_IDLE;
         mem_req_o  <= 1'b0;
         mem_addr_o <= 32'h00000000;
         ptr_r      <= 16'h0000;
         at_end_r   <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (addr_ok) begin
                  mem_req_o  <= 1'b1;
                  mem_addr_o <= {base_r, 2'b00} + {14'h0000, ptr_r, 2'b00};
                  state_r    <= ST_REQ;
               end else if (wr_pend_r && wr_addr_r == `MCRD_PTR_OFS && !fetch_en_r) begin
                  ptr_r    <= hwdata_i[15:0];
                  at_end_r <= 1'b0;
               end else if (ctrl_wr && hwdata_i[`MCRD_FETCH_BIT] && !fetch_en_r) begin
                  at_end_r <= 1'b0;
               end
            end
            ST_REQ: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  state_r   <= ST_IDLE;
                  if (ptr_last) begin
                     ptr_r <= 16'h0000;
                     at_end_r <= !wrap_r;
                  end else begin
                     ptr_r <= ptr_inc;
                  end
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               mem_req_o <= 1'b0;
            end
         endcase
      end
   end

   // Target write path; strobe stands until the wait strobe releases
   always @(posedge mclk_i) begin
      if (!resetn_i) begin
         wait_s1_r <= 1'b1;
         wait_s2_r <= 1'b1;
      end else begin
         wait_s1_r <= target_wait_strobe_n_i;
         wait_s2_r <= wait_s1_r;
      end
   end

   assign fifo_pop = tgt_wr_o && wait_s2_r;

   always @(posedge mclk_i) begin
      if (!resetn_i || purge_r) begin
         tgt_wr_o       <= 1'b0;
         tgt_select_o   <= 3'h0;
         tgt_register_o <= 3'h0;
         tgt_data_o     <= 32'h00000000;
      end else if (!tgt_wr_o || fifo_pop) begin
         tgt_wr_o       <= !fifo_empty && !fifo_pop;
         tgt_select_o   <= tgt_sel_r;
         tgt_register_o <= tgt_reg_r;
         tgt_data_o     <= fifo_rd_data;
      end
   end

   mcrd_fifo #(
      .WIDTH      (32),
      .DEPTH_LOG2 (FIFO_LOG2)
   ) u_fifo (
      .mclk_i     (mclk_i),
      .resetn_i   (resetn_i),
      .purge_i    (purge_r),
      .wr_en_i    (fifo_push),
      .wr_data_i  (mem_data_i),
      .rd_en_i    (fifo_pop),
      .rd_data_o  (fifo_rd_data),
      .empty_o    (fifo_empty),
      .full_o     (fifo_full),
      .level_o    (fifo_level)
   );

   mcrd_wr_timer #(
      .LIMIT      (`MCRD_WR_TIMEOUT)
   ) u_timer (
      .mclk_i     (mclk_i),
      .resetn_i   (resetn_i),
      .active_i   (tgt_wr_o),
      .expired_o  (tmo_pulse)
   );
endmodule // mcrd_ctrl
`default_nettype wire

// File: rtl/mcrd_map.vh
// Register map, field positions, reset values and timing counts of the code-read DMA
`ifndef MCRD_MAP_VH
`define MCRD_MAP_VH
// Register byte offsets
`define MCRD_BASE_OFS      12'h030
`define MCRD_CTRL_OFS      12'h034
`define MCRD_PTR_OFS       12'h038
`define MCRD_STAT_OFS      12'h03c
`define MCRD_MASK_OFS      12'h040
// Control register field positions
`define MCRD_TIMEOUT_BIT   30
`define MCRD_EMPTY_BIT     29
`define MCRD_PURGE_BIT     28
`define MCRD_TGT_HI        22
`define MCRD_TGT_LO        20
`define MCRD_REG_HI        18
`define MCRD_REG_LO        16
`define MCRD_SIZE_HI       14
`define MCRD_SIZE_LO       12
`define MCRD_STEP_HI       10
`define MCRD_STEP_LO       8
`define MCRD_FETCH_BIT     7
`define MCRD_THR_HI        3
`define MCRD_THR_LO        1
`define MCRD_WRAP_BIT      0
// Status and mask register bit positions
`define MCRD_IRQ_REPORT    0
`define MCRD_IRQ_TIMEOUT   1
// Reset values
`define MCRD_SIZE_RST      3'h3
`define MCRD_STEP_RST      3'h1
`define MCRD_THR_RST       3'h6
`define MCRD_BASE_RST      32'h0ffffffc
// Timeout: a write cycle may last this many clock periods
`define MCRD_WR_TIMEOUT    64
`endif

// File: rtl/mcrd_fifo.v
// Code FIFO holding fetched doublewords before they go to the target
`timescale 1ns/100ps
`default_nettype none
module mcrd_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH_LOG2 = 3
) (
   input  wire               mclk_i,
   input  wire               resetn_i,
   input  wire               purge_i,
   input  wire               wr_en_i,
   input  wire [WIDTH-1:0]   wr_data_i,
   input  wire               rd_en_i,
   output wire [WIDTH-1:0]   rd_data_o,
   output wire               empty_o,
   output wire               full_o,
   output wire [DEPTH_LOG2:0] level_o
);
   reg [WIDTH-1:0]      mem_r [0:(1<<DEPTH_LOG2)-1];
   reg [DEPTH_LOG2:0]   wptr_r;
   reg [DEPTH_LOG2:0]   rptr_r;
   wire                 do_wr;
   wire                 do_rd;

   assign do_wr     = wr_en_i && !full_o && !purge_i;
   assign do_rd     = rd_en_i && !empty_o && !purge_i;
   assign level_o   = wptr_r - rptr_r;
   assign empty_o   = (wptr_r == rptr_r);
   assign full_o    = (level_o[DEPTH_LOG2] == 1'b1);
   assign rd_data_o = mem_r[rptr_r[DEPTH_LOG2-1:0]];

   // Purge holds both pointers together, so contents are lost at once
   always @(posedge mclk_i) begin
      if (!resetn_i || purge_i) begin
         wptr_r <= {(DEPTH_LOG2+1){1'b0}};
         rptr_r <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
         if (do_wr)
            wptr_r <= wptr_r + 1'b1;
         if (do_rd)
            rptr_r <= rptr_r + 1'b1;
      end
   end

   // Storage has no reset; only written slots are ever read
   always @(posedge mclk_i) begin
      if (do_wr)
         mem_r[wptr_r[DEPTH_LOG2-1:0]] <= wr_data_i;
   end
endmodule // mcrd_fifo
`default_nettype wire

// File: rtl/mcrd_wr_timer.v
// Counts the length of a write cycle on the local peripheral bus
`timescale 1ns/100ps
`default_nettype none
`include "mcrd_map.vh"
module mcrd_wr_timer #(
   parameter LIMIT = `MCRD_WR_TIMEOUT
) (
   input  wire mclk_i,
   input  wire resetn_i,
   input  wire active_i,
   output wire expired_o
);
   reg [7:0] count_r;
   reg       fired_r;

   // Pulse once when the cycle goes past LIMIT periods
   assign expired_o = active_i && !fired_r && (count_r == LIMIT[7:0]);

   always @(posedge mclk_i) begin
      if (!resetn_i || !active_i) begin
         count_r <= 8'h00;
         fired_r <= 1'b0;
      end else begin
         if (count_r != 8'hff)
            count_r <= count_r + 8'h01;
         if (expired_o)
            fired_r <= 1'b1;
      end
   end
endmodule // mcrd_wr_timer
`default_nettype wire

// File: bench/mcrd_properties.sv
// Port-level assertions of the code-read DMA control block
`timescale 1ns/100ps
`default_nettype none
module mcrd_properties (
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        mem_req_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic        mem_ack_i,
   input wire logic        tgt_wr_o,
   input wire logic [2:0]  tgt_select_o,
   input wire logic [31:0] tgt_data_o,
   input wire logic        target_wait_strobe_n_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   // A held wait with no register write that could purge the cycle
   sequence s_stalled;
      (!target_wait_strobe_n_i && tgt_wr_o && !(hsel_i && htrans_i[1] && hwrite_i))[*3];
   endsequence
   sequence s_ack_end;
      mem_ack_i && mem_req_o;
   endsequence
   chk_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready or not okay");
   chk_reset_quiet: assert property ($rose(resetn_i) |-> !mem_req_o && !tgt_wr_o && hrdata_o == 32'h0)
      else $error("outputs not quiet after reset");
   chk_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("memory request dropped or moved");
   chk_addr_align: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
      else $error("memory address not aligned");
   chk_one_out: assert property (s_ack_end |=> !mem_req_o)
      else $error("request kept after answer");
   chk_ack_write: assert property (s_ack_end |-> ##[1:4] tgt_wr_o)
      else $error("fetched word not written to target");
   chk_tgt_holds: assert property (s_stalled |=> tgt_wr_o && $stable(tgt_data_o) && $stable(tgt_select_o))
      else $error("target write ended while target waits");
   chk_read_hold: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
      else $error("read data changed without a read");
endmodule // mcrd_properties
bind mcrd_ctrl mcrd_properties u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
   .mem_ack_i(mem_ack_i), .tgt_wr_o(tgt_wr_o), .tgt_select_o(tgt_select_o),
   .tgt_data_o(tgt_data_o), .target_wait_strobe_n_i(target_wait_strobe_n_i));
`default_nettype wire

// File: bench/mcrd_partner.sv
// Host memory and target model on the far side of the code-read DMA
`timescale 1ns/100ps
`default_nettype none
module mcrd_partner (
   input  wire logic        mclk_i,
   input  wire logic        req_i,
   input  wire logic [31:0] addr_i,
   input  wire logic        stall_i,
   output logic             ack_o,
   output logic [31:0]      data_o,
   output wire logic        wait_n_o
);
   logic [1:0] cnt_r = 2'h0;
   logic       slow_r = 1'b0;
   initial ack_o = 1'b0;
   initial data_o = 32'h0;
   // Memory answers after one or three cycles by turns; data toggles when not valid
   always @(posedge mclk_i) begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      if (req_i && !ack_o) begin
         if (cnt_r == (slow_r ? 2'h2 : 2'h0)) begin
            ack_o <= 1'b1;
            data_o <= addr_i ^ 32'h5a5aa5a5;
            cnt_r <= 2'h0;
            slow_r <= !slow_r;
         end else begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end
   // Target holds its wait strobe low while told to stall
   assign wait_n_o = !stall_i;
endmodule // mcrd_partner
`default_nettype wire

// File: bench/test_mpeg_code_read_dma_control.sv
// Self-checking bench of the code-read DMA control block
`timescale 1ns/100ps
`default_nettype none
`include "mcrd_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
`define WAIT(c, n) begin k = 0; while (!(c) && k < n) begin @(posedge mclk_i); k++; end if (!(c)) begin fails++; end_of_test; end end
module test_mpeg_code_read_dma_control;
   typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] e; } mcrd_row_t;
   localparam logic [31:0] PAT = 32'h5a5aa5a5;
   localparam int NDW = 2048; // 8 kbyte buffer in doublewords
   logic        mclk_i = 0, resetn_i = 0, hsel = 0, hwrite = 0, stall = 0, tgt_q = 0;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, r, p1;
   wire  [31:0] hrdata, mem_addr, mem_data, tgt_data;
   wire         hready, hresp, mem_req, mem_ack, tgt_wr, wait_n, irq;
   wire  [2:0]  tgt_sel, tgt_reg;
   logic [37:0] q[$];
   int          fails = 0, n_tests = 0, k, n_ack = 0;
   mcrd_row_t   rows [8] = '{'{`MCRD_CTRL_OFS, 32'hffffd5ff, 32'h3077558f},
      '{`MCRD_PTR_OFS, 32'h00000234, 32'h0}, '{`MCRD_CTRL_OFS, 32'h10000000, 32'h30000000},
      '{`MCRD_PTR_OFS, 32'hffff0234, 32'h234}, '{`MCRD_BASE_OFS, 32'hffffffff, 32'hfffffffc},
      '{`MCRD_MASK_OFS, 32'h3, 32'h3}, '{12'h100, 32'hffffffff, 32'h0},
      '{`MCRD_STAT_OFS, 32'hffffffff, 32'h0}};
   always #10 mclk_i = ~mclk_i;
   mcrd_ctrl #(.FIFO_LOG2(3)) DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_data_i(mem_data),
      .tgt_wr_o(tgt_wr), .tgt_select_o(tgt_sel), .tgt_register_o(tgt_reg), .tgt_data_o(tgt_data),
      .target_wait_strobe_n_i(wait_n), .irq_o(irq));
   mcrd_partner u_far (.mclk_i(mclk_i), .req_i(mem_req), .addr_i(mem_addr), .stall_i(stall),
      .ack_o(mem_ack), .data_o(mem_data), .wait_n_o(wait_n));
   // Record each target write at its first cycle, count memory answers
   always @(posedge mclk_i) begin
      tgt_q <= tgt_wr;
      if (tgt_wr && !tgt_q) q.push_back({tgt_sel, tgt_reg, tgt_data});
      if (mem_ack && mem_req) n_ack++;
   end
   task automatic end_of_test;
      if (fails == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One single AHB transfer; waits are bounded so a hung slave ends the run
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      for (int i = 0; i < 2; i++) begin
         k = 0;
         do begin @(posedge mclk_i); k++; end while (hready !== 1'b1 && k < 50);
         if (k >= 50) begin fails++; end_of_test; end
         if (i == 0) begin hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; end
      end
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0, r);
      `CHK(r, e)
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Target 5 register 3, buffer and step both 8 kbyte, purge off
   function automatic logic [31:0] mk(input logic fen, input logic [2:0] thr, input logic wrap);
      return 32'h00530000 | {24'h0, fen, 3'h0, thr, wrap};
   endfunction
   initial begin
      cyc(4);
      resetn_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      // Second reset in mid-run brings every register back
      resetn_i <= 1'b0;
      cyc(2);
      resetn_i <= 1'b1;
      rdc(`MCRD_CTRL_OFS, 32'h3000310c);
      rdc(`MCRD_BASE_OFS, `MCRD_BASE_RST);
      rdc(`MCRD_PTR_OFS, 32'h0);
      rdc(`MCRD_STAT_OFS, 32'h0);
      // Run the last eight words of the buffer without wrap
      wr(`MCRD_BASE_OFS, 32'h00001000);
      wr(`MCRD_PTR_OFS, NDW - 8);
      wr(`MCRD_MASK_OFS, 32'h1);
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h6, 1'b0));
      `WAIT(q.size() == 8, 3000)
      cyc(100);
      `CHK(q.size(), 8)
      foreach (q[i]) `CHK(q[i], {6'h2b, (32'h1000 + 4 * (NDW - 8 + i)) ^ PAT})
      `CHK(irq, 1'b1)
      rdc(`MCRD_STAT_OFS, 32'h1);
      wr(`MCRD_MASK_OFS, 32'h0);
      cyc(1);
      `CHK(irq, 1'b0)
      wr(`MCRD_STAT_OFS, 32'h1);
      rdc(`MCRD_STAT_OFS, 32'h0);
      // Pause in mid-run, then resume across the wrap point
      q.delete();
      wr(`MCRD_CTRL_OFS, mk(1'b0, 3'h6, 1'b1));
      wr(`MCRD_PTR_OFS, NDW - 4);
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h6, 1'b1));
      `WAIT(q.size() >= 2, 500)
      wr(`MCRD_CTRL_OFS, mk(1'b0, 3'h6, 1'b1));
      cyc(30);
      ahb(1'b0, `MCRD_PTR_OFS, 32'h0, p1);
      cyc(60);
      rdc(`MCRD_PTR_OFS, p1);
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h6, 1'b1));
      `WAIT(q.size() >= 10, 1000)
      for (int i = 0; i < 10; i++) `CHK(q[i][31:0], (32'h1000 + 4 * ((NDW - 4 + i) % NDW)) ^ PAT)
      // A stalled target makes one write cycle outlast the limit
      wr(`MCRD_CTRL_OFS, mk(1'b0, 3'h6, 1'b1));
      cyc(50);
      stall <= 1'b1;
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h6, 1'b1));
      `WAIT(tgt_wr === 1'b1, 100)
      cyc(58);
      ahb(1'b0, `MCRD_CTRL_OFS, 32'h0, r);
      `CHK(r[30], 1'b0)
      cyc(10);
      ahb(1'b0, `MCRD_CTRL_OFS, 32'h0, r);
      `CHK(r[30:29], 2'h2)
      wr(`MCRD_MASK_OFS, 32'h2);
      cyc(1);
      `CHK(irq, 1'b1)
      // Purge drops the stuck cycle and empties the buffer
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h6, 1'b1) | 32'h10000000);
      cyc(2);
      `CHK(tgt_wr, 1'b0)
      ahb(1'b0, `MCRD_CTRL_OFS, 32'h0, r);
      `CHK(r[30:28], 3'h7)
      stall <= 1'b0;
      // Clear the flag; a zero threshold never asks for a fetch
      wr(`MCRD_CTRL_OFS, mk(1'b1, 3'h0, 1'b1) | 32'h40000000);
      p1 = n_ack;
      cyc(100);
      `CHK(n_ack, p1)
      ahb(1'b0, `MCRD_CTRL_OFS, 32'h0, r);
      `CHK(r[30:28], 3'h2)
      // The status copy of the timeout stays until it is cleared in the status register
      ahb(1'b0, `MCRD_STAT_OFS, 32'h0, r);
      `CHK(r[1], 1'b1)
      wr(`MCRD_STAT_OFS, 32'h3);
      ahb(1'b0, `MCRD_STAT_OFS, 32'h0, r);
      `CHK(r[1], 1'b0)
      // Codes 7 act as a 64 kbyte ring and a 16 kbyte step
      wr(`MCRD_CTRL_OFS, 32'h0053770c);
      q.delete();
      wr(`MCRD_PTR_OFS, 32'h000017fc);
      wr(`MCRD_CTRL_OFS, 32'h0053778c);
      `WAIT(q.size() >= 8, 500)
      wr(`MCRD_CTRL_OFS, 32'h0053770c);
      cyc(30);
      rdc(`MCRD_STAT_OFS, 32'h0);
      q.delete();
      wr(`MCRD_PTR_OFS, 32'h00003ffc);
      wr(`MCRD_CTRL_OFS, 32'h0053778c);
      `WAIT(q.size() == 4, 500)
      cyc(100);
      `CHK(q.size(), 4)
      `CHK(q[3][31:0], (32'h1000 + 4 * 16383) ^ PAT)
      rdc(`MCRD_STAT_OFS, 32'h1);
      end_of_test;
   end
endmodule // test_mpeg_code_read_dma_control
`default_nettype wire
